// file: tsr_pkg.sv
package tsr_pkg;

  // Command byte values
  localparam logic [7:0] CMD_LOCAL_HI = 8'h00;
  localparam logic [7:0] CMD_REM_S_HI = 8'h01;
  localparam logic [7:0] CMD_GEN_CFG_A = 8'h03;
  localparam logic [7:0] CMD_GEN_CFG_B = 8'h09;
  localparam logic [7:0] CMD_RATE_A = 8'h04;
  localparam logic [7:0] CMD_RATE_B = 8'h0A;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;
  localparam logic [7:0] CMD_REM_S_LO = 8'h10;
  localparam logic [7:0] CMD_OFS_HI = 8'h11;
  localparam logic [7:0] CMD_OFS_LO = 8'h12;
  localparam logic [7:0] CMD_LOCAL_LO = 8'h30;
  localparam logic [7:0] CMD_REM_U_HI = 8'h31;
  localparam logic [7:0] CMD_REM_U_LO = 8'h32;
  localparam logic [7:0] CMD_DIODE_CFG = 8'hBF;

  // Reset values
  localparam logic [7:0] DIODE_CFG_RST = 8'h1F;
  localparam logic [7:0] GEN_CFG_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [7:0] OFS_RST = 8'h00;

  // Field positions and writable masks
  localparam int DC_PIN_SEL = 6;
  localparam int DC_OS_FMASK = 5;
  localparam int DC_CRIT_FMASK = 4;
  localparam int DC_MODEL = 3;
  localparam int GC_STANDBY = 6;
  localparam int GC_RCRIT_MASK = 4;
  localparam int GC_ROS_MASK = 3;
  localparam int GC_LCRIT_MASK = 2;
  localparam int GC_LOS_MASK = 1;
  localparam logic [7:0] DIODE_CFG_WMASK = 8'h7E;
  localparam logic [7:0] DIODE_CFG_FIXED1 = 8'h01;
  localparam logic [7:0] GEN_CFG_WMASK = 8'h5E;
  localparam logic [7:0] RATE_WMASK = 8'h03;
  localparam logic [7:0] OFS_LO_WMASK = 8'hE0;
  localparam logic [1:0] FILTER_ON_CODE = 2'b11;
  localparam logic [1:0] RATE_CONTINUOUS = 2'b00;

  // Conversion periods
  localparam int CLK_KHZ = 20_000;
  localparam int RATE1_MS = 364;
  localparam int RATE2_MS = 1000;
  localparam int RATE3_MS = 2500;
  localparam int RATE1_CYC = RATE1_MS * CLK_KHZ;
  localparam int RATE2_CYC = RATE2_MS * CLK_KHZ;
  localparam int RATE3_CYC = RATE3_MS * CLK_KHZ;
  localparam int TMR_W = 26;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b01,
    CV_BUSY = 2'b10
  } tsr_conv_type;

endpackage

// file: tsr_regmap.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Local high byte signed, one degree per count
// - Local low byte fraction bits 7..5, rest zero
// - Filter on: remote low bits 7..3 valid
// - Filter off: remote low bits 7..5 only
// - Unsigned remote high and low bytes offered
// - Remote resolution eighth or thirty-second degree
// - High read freezes low; low read releases
// - Repeated high reads refresh frozen low byte
// - Diode config bit 6 selects shared pin
// - Bits 5,4 mask diode fault from outputs
// - Bit 3 selects remote diode model
// - Diode config resets 1F, filter code field
// - Remote offset two bytes, reset zero
// - General config two addresses, standby, masks
// - Rate code 00 converts back to back
// - Rate codes set period; field bits 1..0
// - One-shot write starts conversion in standby
// - One-shot returns to standby, reads zero
// - Command byte selects register for access
module tsr_regmap
  import tsr_pkg::*;
#(
  parameter int RATE1_CYCLES = RATE1_CYC,
  parameter int RATE2_CYCLES = RATE2_CYC,
  parameter int RATE3_CYCLES = RATE3_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic conv_done,
  input wire logic [10:0] local_temp_in,
  input wire logic [12:0] remote_signed_in,
  input wire logic [12:0] remote_unsigned_in,
  input wire logic diode_fault,
  input wire logic local_os_hit,
  input wire logic local_crit_hit,
  input wire logic remote_os_hit,
  input wire logic remote_crit_hit,
  input wire logic address_select_pin,
  output logic conv_start,
  output logic conv_busy,
  output logic filter_enable,
  output logic diode_model_select,
  output logic [10:0] remote_offset,
  output logic address_select_level,
  output logic over_temp_shutdown_out,
  output logic over_temp_shutdown_oe,
  output logic crit_out,
  output logic crit_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  function automatic logic [7:0] filt_lo(input logic [4:0] frac,
                                         input logic fon);
    filt_lo = fon ? {frac, 3'b000} : {frac[4:2], 5'b00000};
  endfunction
  function automatic logic [TMR_W-1:0] to_tmr(input int v);
    to_tmr = TMR_W'(v - 1);
  endfunction
  logic [7:0] ptr_r;
  logic [7:0] diode_cfg_r, gen_cfg_r, rate_r, ofs_hi_r, ofs_lo_r;
  logic [7:0] loc_hi_r, loc_lo_r, rs_hi_r, rs_lo_r, ru_hi_r, ru_lo_r;
  logic [7:0] loc_frz_r, rs_frz_r, ru_frz_r;
  logic loc_lock_r, rs_lock_r, ru_lock_r;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic [TMR_W-1:0] tmr_r;
  logic one_shot_pend_r;
  logic start_r;
  tsr_conv_type cv_r, cv_nxt;
  logic os_r, crit_r, addr_r;

  // Command pointer in effect for data and read strobes
  wire [7:0] cur_ptr = cmd_valid ? cmd_byte : ptr_r;
  wire wr_fire = wr_valid;
  wire rd_fire = rd_req;
  wire standby = gen_cfg_r[GC_STANDBY];
  wire filt_on = diode_cfg_r[2:1] == FILTER_ON_CODE;
  wire busy = cv_r == CV_BUSY;
  wire sel_gen = (cur_ptr == CMD_GEN_CFG_A) || (cur_ptr == CMD_GEN_CFG_B);
  wire sel_rate = (cur_ptr == CMD_RATE_A) || (cur_ptr == CMD_RATE_B);
  // Live low bytes; the remote ones are formatted with the current filter setting
  wire [7:0] loc_lo_live = {local_temp_in[2:0], 5'b00000};
  wire [7:0] rs_lo_fmt = filt_lo(remote_signed_in[4:0], filt_on);
  wire [7:0] ru_lo_fmt = filt_lo(remote_unsigned_in[4:0], filt_on);
  // Low byte shown to host: frozen copy while locked
  wire [7:0] loc_lo_view = loc_lock_r ? loc_frz_r : loc_lo_r;
  wire [7:0] rs_lo_view = rs_lock_r ? rs_frz_r : rs_lo_r;
  wire [7:0] ru_lo_view = ru_lock_r ? ru_frz_r : ru_lo_r;
  logic [7:0] rd_mux;
  always_comb begin
    if (cur_ptr == CMD_LOCAL_HI) rd_mux = loc_hi_r;
    else if (cur_ptr == CMD_LOCAL_LO) rd_mux = loc_lo_view;
    else if (cur_ptr == CMD_REM_S_HI) rd_mux = rs_hi_r;
    else if (cur_ptr == CMD_REM_S_LO) rd_mux = rs_lo_view;
    else if (cur_ptr == CMD_REM_U_HI) rd_mux = ru_hi_r;
    else if (cur_ptr == CMD_REM_U_LO) rd_mux = ru_lo_view;
    else if (cur_ptr == CMD_DIODE_CFG) rd_mux = diode_cfg_r;
    else if (cur_ptr == CMD_OFS_HI) rd_mux = ofs_hi_r;
    else if (cur_ptr == CMD_OFS_LO) rd_mux = ofs_lo_r;
    else if (sel_gen) rd_mux = gen_cfg_r;
    else if (sel_rate) rd_mux = rate_r;
    else rd_mux = 8'h00;
  end
  wire [TMR_W-1:0] period = (rate_r[1:0] == 2'b01) ? to_tmr(RATE1_CYCLES) :
                            (rate_r[1:0] == 2'b10) ? to_tmr(RATE2_CYCLES) :
                            to_tmr(RATE3_CYCLES);
  wire auto_due = !standby &&
                  (rate_r[1:0] == RATE_CONTINUOUS || tmr_r == '0);
  wire one_shot_wr = wr_fire && cur_ptr == CMD_ONE_SHOT && standby;
  wire start_now = !busy && (one_shot_pend_r || auto_due);
  always_comb begin
    cv_nxt = cv_r;
    case (cv_r)
      CV_IDLE: if (start_now) cv_nxt = CV_BUSY;
      CV_BUSY: if (conv_done) cv_nxt = CV_IDLE;
      default: cv_nxt = CV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_r <= 8'h00;
      cv_r <= CV_IDLE;
      start_r <= 1'b0;
      one_shot_pend_r <= 1'b0;
      tmr_r <= '0;
    end else begin
      if (cmd_valid) ptr_r <= cmd_byte;
      cv_r <= cv_nxt;
      start_r <= start_now;
      // Pending one-shot is cleared only once it is launched
      if (one_shot_wr) one_shot_pend_r <= 1'b1;
      else if (start_now) one_shot_pend_r <= 1'b0;
      if (start_now) tmr_r <= period;
      else if (tmr_r != '0) tmr_r <= tmr_r - 1'b1;
    end
  end

  // Configuration registers; reserved bits are never stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diode_cfg_r <= DIODE_CFG_RST;
      gen_cfg_r <= GEN_CFG_RST;
      rate_r <= RATE_RST;
      ofs_hi_r <= OFS_RST;
      ofs_lo_r <= OFS_RST;
    end else if (wr_fire) begin
      if (cur_ptr == CMD_DIODE_CFG) begin
        diode_cfg_r <= (wr_data & DIODE_CFG_WMASK) | DIODE_CFG_FIXED1;
      end else if (cur_ptr == CMD_OFS_HI) begin
        ofs_hi_r <= wr_data;
      end else if (cur_ptr == CMD_OFS_LO) begin
        ofs_lo_r <= wr_data & OFS_LO_WMASK;
      end else if (sel_gen) begin
        gen_cfg_r <= wr_data & GEN_CFG_WMASK;
      end else if (sel_rate) begin
        rate_r <= wr_data & RATE_WMASK;
      end
    end
  end

  // Results: stored whole on each completed conversion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loc_hi_r <= 8'h00;
      loc_lo_r <= 8'h00;
      rs_hi_r <= 8'h00;
      rs_lo_r <= 8'h00;
      ru_hi_r <= 8'h00;
      ru_lo_r <= 8'h00;
    end else if (conv_done && busy) begin
      loc_hi_r <= local_temp_in[10:3];
      loc_lo_r <= loc_lo_live;
      rs_hi_r <= remote_signed_in[12:5];
      rs_lo_r <= rs_lo_fmt;
      ru_hi_r <= remote_unsigned_in[12:5];
      ru_lo_r <= ru_lo_fmt;
    end
  end

  // Coherency lock; a high read in the done cycle still gets the old pair
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loc_lock_r <= 1'b0;
      rs_lock_r <= 1'b0;
      ru_lock_r <= 1'b0;
      loc_frz_r <= 8'h00;
      rs_frz_r <= 8'h00;
      ru_frz_r <= 8'h00;
    end else if (rd_fire) begin
      if (cur_ptr == CMD_LOCAL_HI) begin
        loc_lock_r <= 1'b1;
        loc_frz_r <= loc_lo_r;
      end else if (cur_ptr == CMD_LOCAL_LO) begin
        loc_lock_r <= 1'b0;
      end else if (cur_ptr == CMD_REM_S_HI) begin
        rs_lock_r <= 1'b1;
        rs_frz_r <= rs_lo_r;
      end else if (cur_ptr == CMD_REM_S_LO) begin
        rs_lock_r <= 1'b0;
      end else if (cur_ptr == CMD_REM_U_HI) begin
        ru_lock_r <= 1'b1;
        ru_frz_r <= ru_lo_r;
      end else if (cur_ptr == CMD_REM_U_LO) begin
        ru_lock_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_fire;
      if (rd_fire) rd_data_r <= rd_mux;
    end
  end

  // Alarm drive; pins are open drain, pulled low when asserted
  wire fault_os = diode_fault && !diode_cfg_r[DC_OS_FMASK];
  wire fault_crit = diode_fault && !diode_cfg_r[DC_CRIT_FMASK];
  wire os_any = (local_os_hit && !gen_cfg_r[GC_LOS_MASK]) ||
                (remote_os_hit && !gen_cfg_r[GC_ROS_MASK]) ||
                fault_os;
  wire crit_any = (local_crit_hit && !gen_cfg_r[GC_LCRIT_MASK]) ||
                  (remote_crit_hit && !gen_cfg_r[GC_RCRIT_MASK]) ||
                  fault_crit;
  wire pin_is_os = diode_cfg_r[DC_PIN_SEL];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      os_r <= 1'b0;
      crit_r <= 1'b0;
      addr_r <= 1'b0;
    end else begin
      os_r <= pin_is_os && os_any;
      crit_r <= crit_any;
      addr_r <= !pin_is_os && address_select_pin;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign conv_start = start_r;
  assign conv_busy = busy;
  assign filter_enable = filt_on;
  assign diode_model_select = diode_cfg_r[DC_MODEL];
  assign remote_offset = {ofs_hi_r, ofs_lo_r[7:5]};
  assign address_select_level = addr_r;
  assign over_temp_shutdown_out = 1'b0;
  assign over_temp_shutdown_oe = os_r;
  assign crit_out = 1'b0;
  assign crit_oe = crit_r;
  // Checks
  sequence s_reg_read(logic [7:0] c);
    rd_fire && cur_ptr == c;
  endsequence
  property p_local_lock;
    s_reg_read(CMD_LOCAL_HI) ##1 (!rd_fire && !cmd_valid)
    ##1 s_reg_read(CMD_LOCAL_LO) |=> rd_data == $past(loc_lo_r, 3);
  endproperty
  a_local_lock: assert property (p_local_lock)
    else $error("local low byte not frozen");
  property p_refreeze;
    s_reg_read(CMD_REM_S_HI) |=> rs_lock_r && rs_frz_r == $past(rs_lo_r);
  endproperty
  a_refreeze: assert property (p_refreeze)
    else $error("remote low byte not refreshed on high read");
  property p_unlock;
    s_reg_read(CMD_REM_U_LO) |=> !ru_lock_r;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unsigned low byte still locked");
  property p_filter_off_lo;
    (conv_done && busy && !filt_on) |=> rs_lo_r[4:0] == 5'b00000;
  endproperty
  a_filter_off_lo: assert property (p_filter_off_lo)
    else $error("filter off low bits not zero");
  property p_filter_on_lo;
    (conv_done && busy && filt_on)
    |=> ru_lo_r == {$past(remote_unsigned_in[4:0]), 3'b000};
  endproperty
  a_filter_on_lo: assert property (p_filter_on_lo)
    else $error("filter on low byte wrong");
  property p_local_lo_zero;
    rd_valid && $past(cur_ptr) == CMD_LOCAL_LO |-> rd_data[4:0] == 5'h00;
  endproperty
  a_local_lo_zero: assert property (p_local_lo_zero)
    else $error("local low byte unused bits set");
  property p_diode_cfg_fixed;
    rd_valid && $past(cur_ptr) == CMD_DIODE_CFG |-> rd_data[0] && !rd_data[7];
  endproperty
  a_diode_cfg_fixed: assert property (p_diode_cfg_fixed)
    else $error("diode config fixed bits wrong");
  property p_one_shot_start;
    (one_shot_wr && !busy && !one_shot_pend_r) |=> ##1 conv_start;
  endproperty
  a_one_shot_start: assert property (p_one_shot_start)
    else $error("one-shot did not start a conversion");
  property p_no_oneshot_active;
    (wr_fire && cur_ptr == CMD_ONE_SHOT && !standby) |=> !one_shot_pend_r;
  endproperty
  a_no_oneshot_active: assert property (p_no_oneshot_active)
    else $error("one-shot accepted while active");
  property p_one_shot_reads_zero;
    s_reg_read(CMD_ONE_SHOT) |=> rd_data == 8'h00;
  endproperty
  a_one_shot_reads_zero: assert property (p_one_shot_reads_zero)
    else $error("one-shot address read not zero");
  property p_ro_write;
    disable iff (rst || conv_done)
    (wr_fire && cur_ptr == CMD_LOCAL_HI) |=> $stable(loc_hi_r);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only register changed by write");
  property p_continuous;
    (busy && conv_done && !standby && rate_r[1:0] == RATE_CONTINUOUS)
    |=> ##1 conv_start;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous mode did not restart");
endmodule

`default_nettype wire

// file: tsr_conv_model.sv
`timescale 1ns/1ps
`default_nettype none

// Converter on the far side of the conversion link
module tsr_conv_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic [7:0] delay,
  input wire logic [10:0] res_local,
  input wire logic [12:0] res_signed,
  input wire logic [12:0] res_unsigned,
  output logic conv_done,
  output logic [10:0] local_temp_in,
  output logic [12:0] remote_signed_in,
  output logic [12:0] remote_unsigned_in
);
  logic [7:0] cnt_r;

  // Delay 1 raises done two clocks after the start, larger values stretch the conversion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 8'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        cnt_r <= delay;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
        conv_done <= (cnt_r == 8'h01);
      end
    end
  end

  // Results valid only with done; inverted otherwise so a mistimed
  // capture shows up as wrong data
  assign local_temp_in = conv_done ? res_local : ~res_local;
  assign remote_signed_in = conv_done ? res_signed : ~res_signed;
  assign remote_unsigned_in = conv_done ? res_unsigned : ~res_unsigned;
endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tsr_pkg::*;
  localparam int R1 = 10;
  localparam int R2 = 20;
  localparam int R3 = 40;
  localparam int LIMIT = 20000;
  logic clk_sys, rst, cmd_valid, wr_valid, rd_req, rd_valid, conv_done;
  logic conv_start, conv_busy, filter_enable, diode_model_select, crit_out;
  logic address_select_level, over_temp_shutdown_out, over_temp_shutdown_oe;
  logic crit_oe, diode_fault, address_select_pin, local_os_hit;
  logic local_crit_hit, remote_os_hit, remote_crit_hit;
  logic [7:0] cmd_byte, wr_data, rd_data, cv_delay, v, w;
  logic [10:0] local_temp_in, remote_offset, res_l;
  logic [12:0] remote_signed_in, remote_unsigned_in, res_s, res_u;
  logic [31:0] r;
  logic [7:0] expq[$];
  logic [7:0] ra[9] = '{CMD_DIODE_CFG, CMD_GEN_CFG_A, CMD_GEN_CFG_B,
    CMD_RATE_A, CMD_RATE_B, CMD_OFS_HI, CMD_OFS_LO, CMD_ONE_SHOT, 8'h55};
  logic [7:0] rv[9] = '{8'h1f, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic [7:0] pb[11] = '{8'h00, 8'h40, 8'h40, 8'h70, 8'h70, 8'h70, 8'h70,
    8'h70, 8'h70, 8'h70, 8'h40};
  logic [7:0] pg[11] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h50, 8'h40,
    8'h42, 8'h40, 8'h44, 8'h48};
  logic [5:0] pi[11] = '{6'h22, 6'h22, 6'h10, 6'h10, 6'h01, 6'h01, 6'h08,
    6'h08, 6'h04, 6'h04, 6'h02};
  logic [2:0] pe[11] = '{3'h4, 3'h2, 3'h3, 3'h0, 3'h1, 3'h0, 3'h2, 3'h0,
    3'h1, 3'h0, 3'h0};
  int miscompares, tests_run, cycles, i;
  integer seed = 32'hdd1d_408c;

  tsr_regmap #(.RATE1_CYCLES(R1), .RATE2_CYCLES(R2), .RATE3_CYCLES(R3))
  u_dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .wr_valid(wr_valid), .wr_data(wr_data),
    .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .conv_done(conv_done), .local_temp_in(local_temp_in),
    .remote_signed_in(remote_signed_in),
    .remote_unsigned_in(remote_unsigned_in), .diode_fault(diode_fault),
    .local_os_hit(local_os_hit), .local_crit_hit(local_crit_hit),
    .remote_os_hit(remote_os_hit), .remote_crit_hit(remote_crit_hit),
    .address_select_pin(address_select_pin), .conv_start(conv_start),
    .conv_busy(conv_busy), .filter_enable(filter_enable),
    .diode_model_select(diode_model_select), .remote_offset(remote_offset),
    .address_select_level(address_select_level),
    .over_temp_shutdown_out(over_temp_shutdown_out),
    .over_temp_shutdown_oe(over_temp_shutdown_oe), .crit_out(crit_out),
    .crit_oe(crit_oe));

  tsr_conv_model u_conv (.clk_sys(clk_sys), .rst(rst),
    .conv_start(conv_start), .delay(cv_delay), .res_local(res_l),
    .res_signed(res_s), .res_unsigned(res_u), .conv_done(conv_done),
    .local_temp_in(local_temp_in), .remote_signed_in(remote_signed_in),
    .remote_unsigned_in(remote_unsigned_in));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_byte = a;
    wr_valid = 1'b1;
    wr_data = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    wr_valid = 1'b0;
  endtask

  // Expectation is queued when the request goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    expq.push_back(e);
    cmd_valid = 1'b1;
    cmd_byte = a;
    rd_req = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    rd_req = 1'b0;
  endtask

  task automatic wait_conv();
    bit seen;
    int n;
    seen = 1'b0;
    for (n = 0; n < 80; n++) begin
      @(negedge clk_sys);
      if (conv_busy === 1'b1) seen = 1'b1;
      if (seen && conv_busy === 1'b0) break;
    end
    chk({7'h0, seen && conv_busy === 1'b0}, 8'h01, "conversion end");
  endtask

  task automatic shot(input logic [7:0] dly);
    r = rnd();
    res_l = r[10:0];
    r = rnd();
    res_s = r[12:0];
    r = rnd();
    res_u = r[12:0];
    cv_delay = dly;
    r = rnd();
    wr(CMD_ONE_SHOT, r[7:0]);
    wait_conv();
  endtask

  // Third start interval only, so the rate in force is the new one
  task automatic period(input int exp);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (conv_start !== 1'b1 && n < 100);
    end
    chk(n[7:0], exp[7:0], "start period");
  endtask

  task automatic quiet(input int len);
    int n, k;
    k = 0;
    for (n = 0; n < len; n++) begin
      @(negedge clk_sys);
      if (conv_start === 1'b1) k++;
    end
    chk(k[7:0], 8'h00, "start in standby");
  endtask

  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) begin
        miscompares++;
        $display("MISMATCH t=%0t unexpected read answer", $time);
      end else begin
        chk(rd_data, expq.pop_front(), "read data");
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    {cmd_valid, wr_valid, rd_req, diode_fault, address_select_pin} = '0;
    {local_os_hit, local_crit_hit, remote_os_hit, remote_crit_hit} = '0;
    {cmd_byte, wr_data, res_l, res_s, res_u} = '0;
    cv_delay = 8'h04;
    rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    for (i = 0; i < 9; i++) rd(ra[i], rv[i]);
    r = rnd();
    v = r[7:0];
    w = r[15:8];
    wr(CMD_DIODE_CFG, v);
    rd(CMD_DIODE_CFG, (v & 8'h7e) | 8'h01);
    wr(CMD_GEN_CFG_B, v | 8'h40);
    rd(CMD_GEN_CFG_A, (v | 8'h40) & 8'h5e);
    wr(CMD_RATE_B, w);
    rd(CMD_RATE_A, w & 8'h03);
    wr(CMD_OFS_HI, v);
    wr(CMD_OFS_LO, w);
    rd(CMD_OFS_HI, v);
    rd(CMD_OFS_LO, w & 8'he0);
    chk(remote_offset[10:3], v, "offset high");
    chk({remote_offset[2:0], 5'h00}, w & 8'he0, "offset low");
    wr(CMD_DIODE_CFG, 8'h06);
    chk({6'h0, filter_enable, diode_model_select}, 8'h02, "filter on");
    shot(8'h04);
    rd(CMD_LOCAL_HI, res_l[10:3]);
    rd(CMD_LOCAL_LO, {res_l[2:0], 5'h00});
    rd(CMD_REM_S_HI, res_s[12:5]);
    rd(CMD_REM_S_LO, {res_s[4:0], 3'h0});
    rd(CMD_REM_U_HI, res_u[12:5]);
    rd(CMD_REM_U_LO, {res_u[4:0], 3'h0});
    wr(CMD_LOCAL_HI, ~res_l[10:3]);
    rd(CMD_LOCAL_HI, res_l[10:3]);
    rd(CMD_ONE_SHOT, 8'h00);
    quiet(60);
    wr(CMD_DIODE_CFG, 8'h08);
    chk({6'h0, filter_enable, diode_model_select}, 8'h01, "filter off");
    shot(8'h1e);
    rd(CMD_REM_S_LO, {res_s[4:2], 5'h00});
    rd(CMD_REM_U_LO, {res_u[4:2], 5'h00});
    shot(8'h04);
    rd(CMD_REM_S_HI, res_s[12:5]);
    shot(8'h04);
    rd(CMD_REM_S_HI, res_s[12:5]);
    v = {res_s[4:2], 5'h00};
    shot(8'h01);
    rd(CMD_REM_S_LO, v);
    shot(8'h04);
    rd(CMD_REM_S_LO, {res_s[4:2], 5'h00});
    for (i = 0; i < 11; i++) begin
      wr(CMD_DIODE_CFG, pb[i]);
      wr(CMD_GEN_CFG_A, pg[i]);
      {address_select_pin, diode_fault, local_os_hit, local_crit_hit,
        remote_os_hit, remote_crit_hit} = pi[i];
      repeat (3) @(negedge clk_sys);
      chk({3'h0, over_temp_shutdown_out, crit_out, address_select_level,
        over_temp_shutdown_oe, crit_oe}, {5'h00, pe[i]}, "pins");
    end
    {diode_fault, local_os_hit, local_crit_hit} = '0;
    {remote_os_hit, remote_crit_hit} = '0;
    wr(CMD_GEN_CFG_A, 8'h00);
    wr(CMD_ONE_SHOT, 8'h5a);
    wr(CMD_RATE_A, 8'h01);
    period(R1);
    wr(CMD_RATE_B, 8'h02);
    period(R2);
    wr(CMD_RATE_A, 8'h03);
    period(R3);
    wr(CMD_RATE_A, 8'h00);
    // Back to back: four-cycle conversion plus done, idle and launch edges
    period(7);
    repeat (4) @(negedge clk_sys);
    chk(expq.size() == 0 ? 8'h00 : 8'h01, 8'h00, "answers left");
    summarize();
  end
endmodule

`default_nettype wire
